// ==== core/memmap_pkg.sv ====
`default_nettype none
package memmap_pkg;
  // ****************************************************************
  // Program memory
  // ****************************************************************
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] VECTOR_BASE      = 16'h0003;
  localparam int          VECTOR_SHIFT     = 3;
  localparam int          VECTOR_IDX_W     = 5;
  localparam logic [15:0] FLASH_BYTES      = 16'h4800;
  localparam logic [15:0] KBYTE            = 16'h0400;
  localparam int          PAGE_SHIFT       = 8;
  localparam int          BOOT_SIZE_LSB    = 0;
  localparam logic [7:0]  BOOT_CFG_RESET   = 8'hff;
  // ****************************************************************
  // Internal data memory
  // ****************************************************************
  localparam logic [7:0]  UPPER_BASE       = 8'h80;
  localparam logic [7:0]  BIT_AREA_BASE    = 8'h20;
  localparam logic [7:0]  SP_RESET         = 8'h07;
  localparam logic [7:0]  PAGE_SEL_ADDR    = 8'h91;
  localparam logic [7:0]  TIMED_KEY_ADDR   = 8'hc7;
  localparam logic [7:0]  PSW_ADDR         = 8'hd0;
  localparam logic [7:0]  SP_ADDR          = 8'h81;
  localparam logic [7:0]  KEY_FIRST        = 8'haa;
  localparam logic [7:0]  KEY_SECOND       = 8'h55;
  localparam logic [7:0]  PAGE_SEL_RESET   = 8'h00;
  localparam int          PAGE_BIT         = 0;
  localparam int          BANK_LO_BIT      = 3;
  localparam int          BANK_HI_BIT      = 4;
  localparam logic [2:0]  BIT_ADDR_LOW     = 3'h0;
  // Timed-access unlock sequence
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b11
  } key_state_e;
endpackage : memmap_pkg
`default_nettype wire

// ==== core/memory_map_decoder.sv ====
`default_nettype none
module memory_map_decoder #(
  parameter int IRAM_DEPTH = 256,
  parameter int AUXILIARY_RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Boot selection and configuration
  input  wire logic        boot_from_flash_boot,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_wdata,
  // Program fetch
  input  wire logic        fetch_req,
  input  wire logic        fetch_reset,
  input  wire logic        fetch_vector,
  input  wire logic [4:0]  vector_index,
  input  wire logic [15:0] fetch_pc,
  // Data access
  input  wire logic        data_req,
  input  wire logic        data_we,
  input  wire logic        data_indirect,
  input  wire logic        data_bit,
  input  wire logic        data_reg,
  input  wire logic [2:0]  data_reg_num,
  input  wire logic [7:0]  data_addr,
  input  wire logic [7:0]  data_wdata,
  // Stack access
  input  wire logic        push_req,
  input  wire logic        pop_req,
  input  wire logic [7:0]  push_data,
  // Auxiliary RAM access
  input  wire logic        xmove_req,
  input  wire logic        xmove_we,
  input  wire logic [15:0] xmove_addr,
  input  wire logic [7:0]  xmove_wdata,
  // Flash address outputs
  output logic [15:0]      flash_addr,
  output logic             flash_in_boot,
  output logic [7:0]       flash_page,
  output logic [15:0]      app_flash_size,
  // Data answers
  output logic [7:0]       rdata,
  output logic             rvalid,
  output logic             sfr_req,
  output logic             sfr_we,
  output logic [7:0]       sfr_addr,
  output logic [7:0]       sfr_wdata,
  output logic             sfr_page,
  output logic             bad_bit_access,
  // Visible state
  output logic [7:0]       stack_pointer,
  output logic [7:0]       reg_page_register,
  output logic [7:0]       boot_size_config
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Both RAMs are flip-flop arrays indexed by an 8-bit address
  // Only the low byte of an external move address reaches the auxiliary RAM
  logic [7:0]  iram [IRAM_DEPTH];
  logic [7:0]  auxiliary_ram [AUXILIARY_RAM_DEPTH];
  // Control registers; the page register keeps only its select bit
  logic [7:0]  sp_reg;
  logic [7:0]  page_reg;
  logic [7:0]  cfg_reg;
  logic [1:0]  bank_reg;
  // Timed-access tracker; any other data request closes the window
  memmap_pkg::key_state_e key_reg;
  memmap_pkg::key_state_e key_next;

  // ****************************************************************
  // Program memory decode
  // ****************************************************************
  logic [2:0]  boot_area_size_sel;
  logic [15:0] boot_bytes;
  logic [15:0] boot_start;
  logic [15:0] logical_pc;
  logic [15:0] vec_addr;

  // Size field sits in the low bits of the configuration byte
  assign boot_area_size_sel = cfg_reg[memmap_pkg::BOOT_SIZE_LSB +: 3];
  // Any code with the top bit clear selects the largest boot area
  // boot size split
  assign boot_bytes = (boot_area_size_sel == 3'b111) ? 16'h0000 :
                      (boot_area_size_sel == 3'b110) ? memmap_pkg::KBYTE :
                      (boot_area_size_sel == 3'b101) ? 16'(memmap_pkg::KBYTE * 2) :
                      (boot_area_size_sel == 3'b100) ? 16'(memmap_pkg::KBYTE * 3) :
                      16'(memmap_pkg::KBYTE * 4);
  // Boot area sits at the top of the shared flash
  // Application area keeps the bottom, so its vectors never move
  assign boot_start = memmap_pkg::FLASH_BYTES - boot_bytes;
  // Index n lands eight bytes per slot above the first vector
  // fixed vector slots
  assign vec_addr = memmap_pkg::VECTOR_BASE
                  + 16'({11'h000, vector_index} << memmap_pkg::VECTOR_SHIFT);
  // Reset beats a vector, a vector beats the program counter
  // reset fetch point
  assign logical_pc = fetch_reset  ? memmap_pkg::RESET_VECTOR :
                      fetch_vector ? vec_addr : fetch_pc;
  // Boot request without a boot area falls back to the application area
  logic        boot_active;
  logic [15:0] phys_pc;
  assign boot_active = boot_from_flash_boot && (boot_bytes != 16'h0000);
  // Boot code sees its own 0000H; the offset is added after vectoring,
  // which gives the boot area a private vector table
  // boot re-vectoring
  assign phys_pc = boot_active ? 16'(boot_start + logical_pc) : logical_pc;

  // ****************************************************************
  // Data memory decode
  // ****************************************************************
  // One data request per cycle is decoded here
  logic        upper;
  logic        to_sfr;
  logic        bit_ok;
  logic [7:0]  bit_byte;
  logic [7:0]  reg_addr;
  logic [7:0]  iaddr;

  // Top address bit splits lower RAM from the shared upper space
  assign upper = data_addr >= memmap_pkg::UPPER_BASE;
  // direct above 7FH goes to registers
  assign to_sfr = data_req && !data_reg && upper && !data_indirect;
  assign bit_ok = !upper || (data_addr[2:0] == memmap_pkg::BIT_ADDR_LOW);
  // Sixteen bytes of eight bits hold the 128 addressable bits
  // bit address to byte in 20H-2FH
  assign bit_byte = memmap_pkg::BIT_AREA_BASE + {4'h0, data_addr[6:3]};
  // bank base is eight times bank
  assign reg_addr = {3'b000, bank_reg, data_reg_num};
  // Register and bit forms fold into one RAM index
  // lower RAM either way, upper RAM indirect only
  assign iaddr = data_reg ? reg_addr :
                 (data_bit && !upper) ? bit_byte : data_addr;

  // Bit writes rebuild the byte from its current contents,
  // so the other seven bits survive
  logic [7:0]  bit_wbyte;
  assign bit_wbyte = (iram[iaddr] & ~(8'h01 << data_addr[2:0]))
                   | ({7'h00, data_wdata[0]} << data_addr[2:0]);

  // Snooped registers take byte writes only; a bit write to the same
  // address is either refused or touches one bit, never the whole byte
  logic byte_sfr_wr;
  logic page_wr_hit;
  logic key_wr_hit;
  logic psw_wr_hit;
  logic sp_wr_hit;
  assign byte_sfr_wr = to_sfr && data_we && !data_bit;
  assign page_wr_hit = byte_sfr_wr && data_addr == memmap_pkg::PAGE_SEL_ADDR;
  assign key_wr_hit  = byte_sfr_wr && data_addr == memmap_pkg::TIMED_KEY_ADDR;
  assign psw_wr_hit  = byte_sfr_wr && data_addr == memmap_pkg::PSW_ADDR;
  assign sp_wr_hit   = byte_sfr_wr && data_addr == memmap_pkg::SP_ADDR;

  // Idle cycles keep the window open; any other data request shuts it
  // Limitation: one opened window covers a single protected write
  // timed-access key sequence
  always_comb begin
    key_next = memmap_pkg::KEY_IDLE;
    unique case (key_reg)
      memmap_pkg::KEY_IDLE: begin
        if (key_wr_hit && data_wdata == memmap_pkg::KEY_FIRST)
          key_next = memmap_pkg::KEY_HALF;
      end
      memmap_pkg::KEY_HALF: begin
        if (key_wr_hit && data_wdata == memmap_pkg::KEY_SECOND)
          key_next = memmap_pkg::KEY_OPEN;
        else if (!data_req)
          key_next = memmap_pkg::KEY_HALF;
      end
      memmap_pkg::KEY_OPEN: begin
        if (!data_req)
          key_next = memmap_pkg::KEY_OPEN;
      end
      default: key_next = memmap_pkg::KEY_IDLE;
    endcase
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Push beats pop, and both beat a direct stack pointer write
  // stack pointer reset and write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sp_reg   <= memmap_pkg::SP_RESET;
      page_reg <= memmap_pkg::PAGE_SEL_RESET;
      cfg_reg  <= memmap_pkg::BOOT_CFG_RESET;
      bank_reg <= 2'b00;
      key_reg  <= memmap_pkg::KEY_IDLE;
    end else begin
      key_reg <= key_next;
      if (push_req)
        sp_reg <= sp_reg + 8'h01;
      else if (pop_req)
        sp_reg <= sp_reg - 8'h01;
      else if (sp_wr_hit)
        sp_reg <= data_wdata;
      if (page_wr_hit && key_reg == memmap_pkg::KEY_OPEN)
        page_reg <= {7'h00, data_wdata[memmap_pkg::PAGE_BIT]};
      // Only the two bank bits of the status word are kept
      if (psw_wr_hit)
        bank_reg <= {data_wdata[memmap_pkg::BANK_HI_BIT],
                     data_wdata[memmap_pkg::BANK_LO_BIT]};
      if (cfg_wr)
        cfg_reg <= cfg_wdata;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  // RAM contents carry no reset, as real SRAM would not
  // Push wins the port; a data write in the same cycle is lost
  // Refused bit writes to register space never touch the RAM
  // stack always in internal RAM
  always_ff @(posedge clk) begin
    if (push_req)
      iram[8'(sp_reg + 8'h01)] <= push_data;
    else if (data_req && data_we && !to_sfr && (!data_bit || bit_ok))
      iram[iaddr] <= data_bit ? bit_wbyte : data_wdata;
  end

  // Upper address byte is ignored, so the RAM repeats every 256 bytes
  // auxiliary RAM, low address byte
  always_ff @(posedge clk) begin
    if (xmove_req && xmove_we)
      auxiliary_ram[xmove_addr[7:0]] <= xmove_wdata;
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  // Pop reads the slot the pointer names before it moves
  logic [7:0] iram_rd;
  assign iram_rd = pop_req ? iram[sp_reg] :
                   data_bit ? {7'h00, iram[iaddr][data_addr[2:0]]} : iram[iaddr];

  // Registered answers and flash address
  // Each answer stands one cycle; the flash address holds until the next fetch
  // page number from 256-byte pages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata          <= 8'h00;
      rvalid         <= 1'b0;
      sfr_req        <= 1'b0;
      sfr_we         <= 1'b0;
      sfr_addr       <= 8'h00;
      sfr_wdata      <= 8'h00;
      bad_bit_access <= 1'b0;
      flash_addr     <= memmap_pkg::RESET_VECTOR;
      flash_in_boot  <= 1'b0;
      flash_page     <= 8'h00;
      app_flash_size <= memmap_pkg::FLASH_BYTES;
    end else begin
      rvalid         <= (data_req && !data_we && !to_sfr) || pop_req
                        || (xmove_req && !xmove_we);
      rdata          <= (xmove_req && !xmove_we) ? auxiliary_ram[xmove_addr[7:0]] : iram_rd;
      sfr_req        <= to_sfr && (!data_bit || bit_ok);
      sfr_we         <= data_we;
      sfr_addr       <= data_addr;
      sfr_wdata      <= data_wdata;
      bad_bit_access <= data_req && data_bit && !data_indirect && upper && !bit_ok;
      app_flash_size <= boot_start;
      if (fetch_req) begin
        flash_addr    <= phys_pc;
        flash_in_boot <= boot_active;
        flash_page    <= phys_pc[memmap_pkg::PAGE_SHIFT +: 8];
      end
    end
  end

  // State registers are shown as they stand
  assign stack_pointer     = sp_reg;
  assign reg_page_register = page_reg;
  assign sfr_page          = page_reg[memmap_pkg::PAGE_BIT];
  assign boot_size_config  = cfg_reg;

endmodule : memory_map_decoder
`default_nettype wire

// ==== tb/cpu_core_model.sv ====
`default_nettype none
module cpu_core_model (
  // Clock
  input  wire logic  clk,
  // Requests and their qualifiers
  output logic       data_req,
  output logic       push_req,
  output logic       pop_req,
  output logic       xmove_req,
  output logic       data_we,
  output logic       data_indirect,
  output logic       data_bit,
  output logic       data_reg,
  output logic [7:0] data_addr,
  output logic [7:0] data_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial {data_req, push_req, pop_req, xmove_req, data_we, data_indirect} = '0;
  initial {data_bit, data_reg, data_addr, data_wdata} = '0;
  // Mode bits: 0 write, 1 indirect, 2 bit, 3 register, 4 push, 5 pop, 6 auxiliary
  task automatic op(input logic [6:0] m, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {xmove_req, pop_req, push_req, data_reg, data_bit, data_indirect, data_we} = m;
    data_req = ~|m[6:4];
    data_addr = a;
    data_wdata = d;
  endtask : op
  // Released lines flip, so a stale value never passes for live data
  task automatic idle();
    @(negedge clk);
    {data_req, push_req, pop_req, xmove_req} = '0;
    data_addr = ~data_addr;
    data_wdata = ~data_wdata;
  endtask : idle
  // key pair back to back, then the page write; a bad first key is refused
  task automatic page_wr(input logic [7:0] v, input logic good);
    op(7'h01, memmap_pkg::TIMED_KEY_ADDR, good ? memmap_pkg::KEY_FIRST : 8'h00);
    op(7'h01, memmap_pkg::TIMED_KEY_ADDR, memmap_pkg::KEY_SECOND);
    op(7'h01, memmap_pkg::PAGE_SEL_ADDR, v);
    idle();
  endtask : page_wr
endmodule : cpu_core_model
`default_nettype wire

// ==== tb/memory_map_decoder_assertions.sv ====
`default_nettype none
module memory_map_decoder_assertions (
  // Clock, reset and requests
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        data_req,
  input wire logic        data_we,
  input wire logic        data_indirect,
  input wire logic        data_bit,
  input wire logic        data_reg,
  input wire logic [7:0]  data_addr,
  input wire logic [7:0]  data_wdata,
  input wire logic        push_req,
  input wire logic        pop_req,
  // Answers and state
  input wire logic [15:0] app_flash_size,
  input wire logic        rvalid,
  input wire logic        sfr_req,
  input wire logic [7:0]  sfr_addr,
  input wire logic        bad_bit_access,
  input wire logic [7:0]  stack_pointer,
  input wire logic [7:0]  reg_page_register,
  input wire logic [7:0]  boot_size_config
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Byte access helpers; the page register is held inside, so it is left out
  wire logic plain = data_req && !data_bit && !data_reg;
  wire logic [15:0] boot_bytes =
    boot_size_config[2] ? {4'h0, ~boot_size_config[1:0], 10'h000} : 16'h1000;
  property p_reset; $rose(nrst) |-> stack_pointer == 8'h07 && reg_page_register == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_app; $stable(boot_size_config) |-> app_flash_size == 16'h4800 - boot_bytes;
  endproperty
  a_app: assert property (p_app) else $error("flash split wrong");
  property p_ram; plain && !data_we && (data_indirect || !data_addr[7]) |=> rvalid && !sfr_req;
  endproperty
  a_ram: assert property (p_ram) else $error("ram read not answered");
  property p_sfr; plain && !data_indirect && data_addr[7] && data_addr != 8'h91
    |=> sfr_req && !rvalid && sfr_addr == $past(data_addr); endproperty
  a_sfr: assert property (p_sfr) else $error("direct high not routed");
  property p_push; push_req && !pop_req |=> stack_pointer == $past(stack_pointer) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pop; pop_req && !push_req |=> stack_pointer == $past(stack_pointer) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop step wrong");
  property p_page; !$stable(reg_page_register) |-> $past(plain && data_addr == 8'h91)
    && $past(data_wdata, 2) == 8'h55 && $past(data_wdata, 3) == 8'haa; endproperty
  a_page: assert property (p_page) else $error("page changed without key");
  property p_bad; bad_bit_access |-> $past(data_req && data_bit); endproperty
  a_bad: assert property (p_bad) else $error("stray bad bit flag");
endmodule : memory_map_decoder_assertions
bind memory_map_decoder memory_map_decoder_assertions u_chk (
  .clk(clk), .nrst(nrst), .data_req(data_req), .data_we(data_we),
  .data_indirect(data_indirect), .data_bit(data_bit), .data_reg(data_reg),
  .data_addr(data_addr), .data_wdata(data_wdata), .push_req(push_req), .pop_req(pop_req),
  .app_flash_size(app_flash_size), .rvalid(rvalid), .sfr_req(sfr_req), .sfr_addr(sfr_addr),
  .bad_bit_access(bad_bit_access), .stack_pointer(stack_pointer),
  .reg_page_register(reg_page_register), .boot_size_config(boot_size_config));
`default_nettype wire

// ==== tb/memory_map_decoder_tb.sv ====
`default_nettype none
module memory_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench and partner lines, design outputs
  logic        clk, nrst, boot_from_flash_boot, cfg_wr, fetch_req, fetch_reset;
  logic        fetch_vector, data_req, data_we, data_indirect, data_bit, data_reg;
  logic        push_req, pop_req, xmove_req, flash_in_boot, rvalid, sfr_req, sfr_we;
  logic        sfr_page, bad_bit_access;
  logic [4:0]  vector_index;
  logic [7:0]  cfg_wdata, data_addr, data_wdata, rdata, sfr_addr, sfr_wdata, flash_page;
  logic [7:0]  stack_pointer, reg_page_register, boot_size_config;
  logic [15:0] fetch_pc, flash_addr, app_flash_size;
  int          errors, tests_run;
  // Narrow qualifiers are slices of the shared partner lines
  memory_map_decoder DUT (
    .clk(clk), .nrst(nrst), .boot_from_flash_boot(boot_from_flash_boot), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .fetch_req(fetch_req), .fetch_reset(fetch_reset),
    .fetch_vector(fetch_vector), .vector_index(vector_index), .fetch_pc(fetch_pc),
    .data_req(data_req), .data_we(data_we), .data_indirect(data_indirect),
    .data_bit(data_bit), .data_reg(data_reg), .data_reg_num(data_addr[2:0]),
    .data_addr(data_addr), .data_wdata(data_wdata), .push_req(push_req), .pop_req(pop_req),
    .push_data(data_wdata), .xmove_req(xmove_req), .xmove_we(data_we),
    .xmove_addr({8'h00, data_addr}), .xmove_wdata(data_wdata), .flash_addr(flash_addr),
    .flash_in_boot(flash_in_boot), .flash_page(flash_page), .app_flash_size(app_flash_size),
    .rdata(rdata), .rvalid(rvalid), .sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_page(sfr_page), .bad_bit_access(bad_bit_access),
    .stack_pointer(stack_pointer), .reg_page_register(reg_page_register),
    .boot_size_config(boot_size_config));
  cpu_core_model cpu (.clk(clk), .data_req(data_req), .push_req(push_req), .pop_req(pop_req),
    .xmove_req(xmove_req), .data_we(data_we), .data_indirect(data_indirect),
    .data_bit(data_bit), .data_reg(data_reg), .data_addr(data_addr), .data_wdata(data_wdata));
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // One fetch; its address is looked at in the cycle after it is taken
  task automatic fetch(input logic r, input logic v, input logic [4:0] i);
    @(negedge clk);
    {fetch_req, fetch_reset, fetch_vector, vector_index} = {1'b1, r, v, i};
    @(negedge clk);
    fetch_req = 1'b0;
  endtask : fetch
  task automatic wr(input logic [6:0] m, input logic [7:0] a, input logic [7:0] d);
    cpu.op(m, a, d);
    cpu.idle();
  endtask : wr
  task automatic rd(input logic [6:0] m, input logic [7:0] a, input logic [7:0] e, string w);
    wr(m, a, 8'h00);
    chk(w, {rvalid, 7'h00, rdata}, {1'b1, 7'h00, e});
  endtask : rd
  task automatic t_reset_fetch();
    chk("reset state", {stack_pointer, reg_page_register}, 16'h0700);
    chk("reset split", app_flash_size, 16'h4800);
    fetch(1'b0, 1'b0, 5'h00);
    chk("plain fetch", flash_addr, 16'h0123);
    fetch(1'b1, 1'b0, 5'h00);
    chk("reset fetch", flash_addr, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      fetch(1'b0, 1'b1, 5'(i));
      chk("vector", flash_addr, 16'h0003 + 16'(8 * i));
    end
  endtask : t_reset_fetch
  task automatic t_boot();
    logic [7:0]  cfg [5] = '{8'hff, 8'hfe, 8'hfd, 8'hfc, 8'hf8};
    logic [15:0] app [5] = '{16'h4800, 16'h4400, 16'h4000, 16'h3c00, 16'h3800};
    logic [15:0] base;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      {boot_from_flash_boot, cfg_wr, cfg_wdata} = {2'b11, cfg[i]};
      @(negedge clk);
      cfg_wr = 1'b0;
      fetch(1'b1, 1'b0, 5'h00);
      base = (i == 0) ? 16'h0000 : app[i];
      chk("app size", app_flash_size, app[i]);
      chk("boot config", {8'h00, boot_size_config}, {8'h00, cfg[i]});
      chk("boot start", flash_addr, base);
      chk("page", {7'h00, flash_in_boot, flash_page}, {7'h00, i != 0, base[15:8]});
      fetch(1'b0, 1'b1, 5'h01);
      chk("boot vector", flash_addr, base + 16'h000b);
    end
  endtask : t_boot
  // Bank 2 register, bit area, upper RAM against register space, auxiliary RAM
  task automatic t_data();
    wr(7'h01, memmap_pkg::PSW_ADDR, 8'h10);
    chk("sfr write", {sfr_req, sfr_we, 6'h00, sfr_wdata}, 16'hc010);
    wr(7'h09, 8'h03, 8'h5c);
    rd(7'h00, 8'h13, 8'h5c, "bank reg");
    rd(7'h02, 8'h13, 8'h5c, "indirect low");
    wr(7'h01, 8'h21, 8'h00);
    wr(7'h05, 8'h0b, 8'h01);
    rd(7'h00, 8'h21, 8'h08, "bit area");
    wr(7'h03, 8'h90, 8'ha5);
    wr(7'h00, 8'h90, 8'h00);
    chk("direct high", {sfr_req, sfr_we, 6'h00, sfr_addr}, 16'h8090);
    wr(7'h41, 8'h90, 8'h3c);
    rd(7'h40, 8'h90, 8'h3c, "aux ram");
    rd(7'h02, 8'h90, 8'ha5, "upper ram");
  endtask : t_data
  // Stack moved high, aux write at the same address must not reach it
  task automatic t_stack();
    wr(7'h01, memmap_pkg::SP_ADDR, 8'hf0);
    wr(7'h05, memmap_pkg::SP_ADDR, 8'h33);
    chk("bad bit", {bad_bit_access, sfr_req, 6'h00, stack_pointer}, 16'h80f0);
    wr(7'h10, 8'h00, 8'h11);
    wr(7'h10, 8'h00, 8'h22);
    rd(7'h02, 8'hf2, 8'h22, "push slot");
    wr(7'h41, 8'hf2, 8'h99);
    wr(7'h20, 8'h00, 8'h00);
    chk("pop", {stack_pointer, rdata}, 16'hf122);
  endtask : t_stack
  task automatic t_page();
    cpu.page_wr(8'h01, 1'b0);
    chk("page locked", {7'h00, sfr_page, reg_page_register}, 16'h0000);
    cpu.page_wr(8'h01, 1'b1);
    chk("page one", {7'h00, sfr_page, reg_page_register}, 16'h0101);
    cpu.page_wr(8'h00, 1'b1);
    chk("page zero", {7'h00, sfr_page, reg_page_register}, 16'h0000);
  endtask : t_page
  // Main sequence
  initial begin
    {nrst, boot_from_flash_boot, cfg_wr, fetch_req, fetch_reset, fetch_vector} = '0;
    {vector_index, cfg_wdata, fetch_pc} = {5'h00, 8'h00, 16'h0123};
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_reset_fetch();
    t_boot();
    t_data();
    t_stack();
    t_page();
    summarize();
  end
  // Watchdog far beyond the hundred or so cycles the scenarios take
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule : memory_map_decoder_tb
`default_nettype wire
